// ==== shared/tsens_consts.svh ====
// Purpose: Constants of the temperature sensor command decoder.
// Assumes: Included by bare name wherever a value is needed.
// Notes:   Threshold reset values are 80 and 75 degrees in 12-bit form.
`ifndef TSENS_CONSTS_SVH
`define TSENS_CONSTS_SVH

`define TS_FAMILY_CODE        4'h9
`define TS_CMD_READ_TEMP      8'hAA
`define TS_CMD_HIGH_THRESHOLD 8'hA1
`define TS_CMD_LOW_THRESHOLD  8'hA2
`define TS_CMD_CONFIG         8'hAC
`define TS_CMD_START_CONV     8'h51
`define TS_CMD_STOP_CONV      8'h22
`define TS_HIGH_THRESHOLD_RST 12'h500
`define TS_LOW_THRESHOLD_RST  12'h4B0
`define TS_TEMP_RST           12'h000
`define TS_CFG_RST            7'h0C
`define TS_CFG_ONE_SHOT       0
`define TS_CFG_RES_LSB        2
`define TS_LAST_BIT_CNT       4'h7
`define TS_ACK_BIT_CNT        4'h8
`define TS_FILL_BYTE          8'hFF

`endif

// ==== shared/tsens_pkg.sv ====
// Purpose: Types shared by the decoder and its bus byte engine.
// Assumes: Nothing beyond the constants header.
// Notes:   Event kinds travel from the bus clock to the system clock.
package tsens_pkg;
   typedef enum logic [1:0] {EVT_CTRL_WR, EVT_CTRL_RD, EVT_DATA} link_evt_t;
   typedef enum {PH_IDLE, PH_CMD, PH_DATA} cmd_phase_t;
endpackage

// ==== shared/twi_link_if.sv ====
// Purpose: Carrier between the byte engine and the command decoder.
// Assumes: Byte events are toggles; words are held stable while read.
// Notes:   link_clear is an asynchronous reset for the bus clock logic.
`timescale 1ns/1ps
`default_nettype none
interface twi_link_if;
   import tsens_pkg::*;
   logic        link_clear;
   logic [15:0] read_word;
   logic        evt_tog;
   link_evt_t   evt_kind;
   logic [7:0]  evt_byte;
   modport dec  (output link_clear, read_word,
                 input  evt_tog, evt_kind, evt_byte);
   modport link (input  link_clear, read_word,
                 output evt_tog, evt_kind, evt_byte);
endinterface
`default_nettype wire

// ==== design/twi_byte_link.sv ====
// Purpose: Bus-clock byte engine: address match, acknowledge, shifting.
// Assumes: scl is the bus clock; data is sampled on its rising edge.
// Notes:   Held in reset by rst or by a START or STOP seen elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "tsens_consts.svh"
module twi_byte_link
   import tsens_pkg::*;
(
   input  wire logic       scl,
   input  wire logic       rst,
   input  wire logic       sda_in,
   input  wire logic [2:0] addr_pins,
   output var  logic       sda_oe,
   twi_link_if.link        lk
);
   logic       link_rst;
   logic [2:0] addr_m, addr_s;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sr, next_sr, byte_in, tx_byte;
   logic       is_ctrl, next_is_ctrl, addressed, next_addressed;
   logic       rw, next_rw, ack_pend, next_ack_pend, match_now;
   logic [1:0] tx_idx, next_tx_idx;
   logic       next_tog, next_oe;
   link_evt_t  next_kind;
   logic [7:0] next_evt_byte;

   assign link_rst  = rst | lk.link_clear;
   assign byte_in   = {sr[6:0], sda_in};
   assign match_now = byte_in[7:4] == `TS_FAMILY_CODE
                      && byte_in[3:1] == addr_s;

   // Address pins are straps; two flops keep them off the decode path.
   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         addr_m <= 3'h0;
         addr_s <= 3'h0;
      end else begin
         addr_m <= addr_pins;
         addr_s <= addr_m;
      end
   end

   always_comb begin
      next_cnt       = cnt;
      next_sr        = sr;
      next_is_ctrl   = is_ctrl;
      next_addressed = addressed;
      next_rw        = rw;
      next_ack_pend  = ack_pend;
      next_tx_idx    = tx_idx;
      next_tog       = lk.evt_tog;
      next_kind      = lk.evt_kind;
      next_evt_byte  = lk.evt_byte;
      if (cnt != `TS_ACK_BIT_CNT) begin
         next_sr  = byte_in;
         next_cnt = cnt + 4'h1;
         if (cnt == `TS_LAST_BIT_CNT) begin
            next_ack_pend = 1'b0;
            if (is_ctrl) begin
               next_is_ctrl = 1'b0;
               if (match_now) begin                     // [RULE_01] [RULE_02]
                  next_addressed = 1'b1;
                  next_rw        = byte_in[0];          // [RULE_03]
                  next_ack_pend  = 1'b1;                // [RULE_04]
                  next_tx_idx    = 2'h0;
                  next_tog       = ~lk.evt_tog;
                  next_kind      = byte_in[0] ? EVT_CTRL_RD : EVT_CTRL_WR;
                  next_evt_byte  = byte_in;
               end
            end else if (addressed && !rw) begin
               next_ack_pend = 1'b1;                    // [RULE_05]
               next_tog      = ~lk.evt_tog;
               next_kind     = EVT_DATA;
               next_evt_byte = byte_in;
            end
         end
      end else begin
         next_cnt      = 4'h0;
         next_ack_pend = 1'b0;
         if (addressed && rw && !ack_pend) begin
            if (sda_in) begin
               next_addressed = 1'b0;                   // [RULE_17]
            end else if (tx_idx != 2'h2) begin
               next_tx_idx = tx_idx + 2'h1;             // [RULE_16]
            end
         end
      end
   end

   always_ff @(posedge scl or posedge link_rst) begin
      if (link_rst) begin
         cnt       <= 4'h0;
         sr        <= 8'h00;
         is_ctrl   <= 1'b1;
         addressed <= 1'b0;
         rw        <= 1'b0;
         ack_pend  <= 1'b0;
         tx_idx    <= 2'h0;
      end else begin
         cnt       <= next_cnt;
         sr        <= next_sr;
         is_ctrl   <= next_is_ctrl;
         addressed <= next_addressed;
         rw        <= next_rw;
         ack_pend  <= next_ack_pend;
         tx_idx    <= next_tx_idx;
      end
   end

   // Event fields survive START and STOP so the toggle stays consistent.
   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         lk.evt_tog  <= 1'b0;
         lk.evt_kind <= EVT_DATA;
         lk.evt_byte <= 8'h00;
      end else begin
         lk.evt_tog  <= next_tog;
         lk.evt_kind <= next_kind;
         lk.evt_byte <= next_evt_byte;
      end
   end

   always_comb begin
      case (tx_idx)
         2'h0:    tx_byte = lk.read_word[15:8];
         2'h1:    tx_byte = lk.read_word[7:0];
         default: tx_byte = `TS_FILL_BYTE;
      endcase
      if (cnt == `TS_ACK_BIT_CNT) begin
         next_oe = ack_pend;
      end else begin
         next_oe = addressed && rw && !tx_byte[~cnt[2:0]];
      end
   end

   // Drive changes on the falling edge, while the bus clock is low.
   always_ff @(negedge scl or posedge link_rst) begin
      if (link_rst) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= next_oe;
      end
   end

   AST_FAMILY_GATE: assert property (@(posedge scl) disable iff (link_rst)
      (cnt == `TS_LAST_BIT_CNT && is_ctrl
       && byte_in[7:4] != `TS_FAMILY_CODE) |=> !addressed) // [RULE_01]
      else $error("addressed with wrong family code");
   AST_SELECT_GATE: assert property (@(posedge scl) disable iff (link_rst)
      (cnt == `TS_LAST_BIT_CNT && is_ctrl
       && byte_in[3:1] != addr_s) |=> !ack_pend) // [RULE_02]
      else $error("acknowledged a foreign device select");
   AST_DIRECTION: assert property (@(posedge scl) disable iff (link_rst)
      (cnt == `TS_LAST_BIT_CNT && is_ctrl && match_now)
      |=> rw == $past(sda_in)) // [RULE_03]
      else $error("direction bit not taken");
   AST_ACK_MATCH: assert property (@(posedge scl) disable iff (link_rst)
      (cnt == `TS_LAST_BIT_CNT && is_ctrl && match_now)
      |=> ack_pend && sda_oe) // [RULE_04]
      else $error("no acknowledge on matching control byte");
   AST_NACK_RELEASE: assert property (@(posedge scl) disable iff (link_rst)
      (cnt == `TS_ACK_BIT_CNT && addressed && rw && !ack_pend && sda_in)
      |=> !addressed && !sda_oe) // [RULE_17]
      else $error("data line held after not-acknowledge");
endmodule
`default_nettype wire

// ==== design/temp_sensor_i2c_command_decoder.sv ====
// Purpose: Command layer of a two-wire temperature sensor slave.
// Assumes: Converter logic runs on ref_clk; scl is the bus clock.
// Notes:   START and STOP are found on ref_clk and reset the bus logic.
//
// Contract
// RULE_01: First byte after START is control; upper nibble must be 1001.
// RULE_02: Next three control bits must equal the three address pins.
// RULE_03: Control byte LSB: 1 selects read, 0 selects write.
// RULE_04: Acknowledge only on full match; otherwise leave the bus alone.
// RULE_05: Write: address, then one acknowledged command byte, then data.
// RULE_06: Read: command written first, repeated START, address with 1.
// RULE_07: Read temperature returns last result without starting conversion.
// RULE_08: Master may stop after first temperature byte with NACK.
// RULE_09: High threshold command writes or reads the high threshold.
// RULE_10: Low threshold command writes or reads the low threshold.
// RULE_11: Twelve-bit registers move as one or two bytes, MSB first.
// RULE_12: Config command moves exactly one byte of configuration/status.
// RULE_13: Start command: one-shot converts once, continuous keeps going.
// RULE_14: Stop command finishes current conversion then stays idle.
// RULE_15: In one-shot mode each reading needs its own start command.
// RULE_16: Reads send the most significant byte first, then the LSB.
// RULE_17: On master NACK the device releases the data line high.
// RULE_18: Values are two's complement; bits below resolution are masked.
// RULE_19: Unknown command bytes are acknowledged but change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "tsens_consts.svh"
module temp_sensor_i2c_command_decoder
   import tsens_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        scl,
   input  wire logic        sda_in,
   input  wire logic        addr_pin_2,
   input  wire logic        addr_pin_1,
   input  wire logic        addr_pin_0,
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_result,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             conv_run,
   output logic [7:0]       config_status,
   output logic [11:0]      high_limit,
   output logic [11:0]      low_limit
);
   twi_link_if lk ();

   logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic        tog_m, tog_s, tog_d, evt_new;
   logic        bus_start, bus_stop, next_clear;
   cmd_phase_t  phase, next_phase;
   logic [7:0]  cmd, next_cmd;
   logic [1:0]  idx, next_idx;
   logic [11:0] high_threshold, next_high;
   logic [11:0] low_threshold, next_low;
   logic [11:0] temperature_result, next_temp;
   logic [6:0]  cfg, next_cfg;
   logic        conv_active, next_conv_active;
   logic        stop_pend, next_stop_pend;
   logic [15:0] next_read_word;
   logic [11:0] mask;
   logic        cmd_evt, data_evt;

   twi_byte_link u_link (
      .scl       (scl),
      .rst       (rst),
      .sda_in    (sda_in),
      .addr_pins ({addr_pin_2, addr_pin_1, addr_pin_0}),
      .sda_oe    (sda_oe),
      .lk        (lk.link)
   );

   // ********************************************************
   // Bus condition detection and event crossing
   // ********************************************************

   // Pins and the event toggle pass two flops before any use.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         tog_m <= 1'b0;
         tog_s <= 1'b0;
         tog_d <= 1'b0;
      end else begin
         scl_m <= scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         tog_m <= lk.evt_tog;
         tog_s <= tog_m;
         tog_d <= tog_s;
      end
   end

   // Both clock samples must read high; a data bit set up just before a
   // rising edge then cannot pose as a START or a STOP.
   assign bus_start = scl_s && scl_d && sda_d && !sda_s;
   assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;
   assign evt_new   = tog_s ^ tog_d;
   assign cmd_evt   = evt_new && lk.evt_kind == EVT_DATA && phase == PH_CMD;
   assign data_evt  = evt_new && lk.evt_kind == EVT_DATA && phase == PH_DATA;

   // The clear is released only once the bus clock is low again, so the
   // bus logic leaves reset well away from its next rising edge.
   always_comb begin
      next_clear = lk.link_clear;
      if (bus_start || bus_stop) begin
         next_clear = 1'b1;
      end else if (!scl_s) begin
         next_clear = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lk.link_clear <= 1'b1;
      end else begin
         lk.link_clear <= next_clear;
      end
   end

   // ********************************************************
   // Command decode, registers and conversion control
   // ********************************************************

   always_comb begin
      next_phase       = phase;
      next_cmd         = cmd;
      next_idx         = idx;
      next_high        = high_threshold;
      next_low         = low_threshold;
      next_cfg         = cfg;
      next_temp        = temperature_result;
      next_conv_active = conv_active;
      next_stop_pend   = stop_pend;
      if (conv_done) begin
         next_temp = conv_result;
         if (cfg[`TS_CFG_ONE_SHOT] || stop_pend) begin
            next_conv_active = 1'b0;                    // [RULE_13] [RULE_14]
            next_stop_pend   = 1'b0;
         end
      end
      if (evt_new) begin
         case (lk.evt_kind)
            EVT_CTRL_WR: begin
               next_phase = PH_CMD;                     // [RULE_05]
            end
            EVT_CTRL_RD: begin
               next_phase = PH_IDLE;                    // [RULE_06]
            end
            default: begin
               if (phase == PH_CMD) begin
                  next_cmd   = lk.evt_byte;
                  next_idx   = 2'h0;
                  next_phase = PH_DATA;
                  if (lk.evt_byte == `TS_CMD_START_CONV) begin
                     next_conv_active = 1'b1;           // [RULE_13]
                     next_stop_pend   = 1'b0;
                  end else if (lk.evt_byte == `TS_CMD_STOP_CONV) begin
                     next_stop_pend = next_conv_active; // [RULE_14]
                  end
               end else if (phase == PH_DATA) begin
                  if (idx != 2'h2) begin
                     next_idx = idx + 2'h1;
                  end
                  case (cmd)
                     `TS_CMD_HIGH_THRESHOLD: begin      // [RULE_09] [RULE_11]
                        if (idx == 2'h0) begin
                           next_high[11:4] = lk.evt_byte;
                        end else if (idx == 2'h1) begin
                           next_high[3:0] = lk.evt_byte[7:4];
                        end
                     end
                     `TS_CMD_LOW_THRESHOLD: begin       // [RULE_10] [RULE_11]
                        if (idx == 2'h0) begin
                           next_low[11:4] = lk.evt_byte;
                        end else if (idx == 2'h1) begin
                           next_low[3:0] = lk.evt_byte[7:4];
                        end
                     end
                     `TS_CMD_CONFIG: begin              // [RULE_12]
                        if (idx == 2'h0) begin
                           next_cfg = lk.evt_byte[6:0];
                        end
                     end
                     default: begin                     // [RULE_19]
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase              <= PH_IDLE;
         cmd                <= 8'h00;
         idx                <= 2'h0;
         high_threshold     <= `TS_HIGH_THRESHOLD_RST;
         low_threshold      <= `TS_LOW_THRESHOLD_RST;
         cfg                <= `TS_CFG_RST;
         temperature_result <= `TS_TEMP_RST;
         conv_active        <= 1'b0;
         stop_pend          <= 1'b0;
      end else begin
         phase              <= next_phase;
         cmd                <= next_cmd;
         idx                <= next_idx;
         high_threshold     <= next_high;
         low_threshold      <= next_low;
         cfg                <= next_cfg;
         temperature_result <= next_temp;
         conv_active        <= next_conv_active;
         stop_pend          <= next_stop_pend;
      end
   end

   // ********************************************************
   // Read word and outputs
   // ********************************************************

   // The read word is held steady between register updates; a result
   // landing mid-read can tear the two bytes, a known limitation.
   always_comb begin
      case (cmd)
         `TS_CMD_READ_TEMP:                             // [RULE_07] [RULE_16]
            next_read_word = {temperature_result, 4'h0};
         `TS_CMD_HIGH_THRESHOLD:
            next_read_word = {high_threshold, 4'h0};    // [RULE_09]
         `TS_CMD_LOW_THRESHOLD:
            next_read_word = {low_threshold, 4'h0};     // [RULE_10]
         `TS_CMD_CONFIG:
            next_read_word = {!conv_active, cfg, `TS_FILL_BYTE}; // [RULE_12]
         default:
            next_read_word = {`TS_FILL_BYTE, `TS_FILL_BYTE};
      endcase
      mask = 12'hFFF << (2'h3 - cfg[`TS_CFG_RES_LSB +: 2]);   // [RULE_18]
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sda_out       <= 1'b0;
         lk.read_word  <= 16'hFFFF;
         conv_run      <= 1'b0;
         config_status <= 8'h00;
         high_limit    <= 12'h000;
         low_limit     <= 12'h000;
      end else begin
         // The pin only ever pulls low; the enable sets the level.
         sda_out       <= 1'b0;
         lk.read_word  <= next_read_word;
         conv_run      <= next_conv_active;
         config_status <= {!next_conv_active, next_cfg};
         high_limit    <= high_threshold & mask;
         low_limit     <= low_threshold & mask;
      end
   end

   // ********************************************************
   // Checks
   // ********************************************************

   sequence seq_cmd(logic [7:0] code);
      cmd_evt && lk.evt_byte == code;
   endsequence

   sequence seq_data(logic [7:0] code, logic [1:0] pos);
      data_evt && cmd == code && idx == pos;
   endsequence

   AST_CMD_AFTER_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
      (evt_new && lk.evt_kind == EVT_CTRL_WR) |=> phase == PH_CMD) // [RULE_05]
      else $error("command byte not expected after write address");
   AST_READ_TEMP: assert property (@(posedge ref_clk) disable iff (rst)
      (seq_cmd(`TS_CMD_READ_TEMP) ##0 !conv_done)
      |=> conv_active == $past(conv_active)
      ##1 lk.read_word[15:4] == $past(temperature_result)) // [RULE_07]
      else $error("read temperature misbehaved");
   AST_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
      seq_data(`TS_CMD_HIGH_THRESHOLD, 2'h0)
      |=> high_threshold[11:4] == $past(lk.evt_byte)) // [RULE_09]
      else $error("high threshold MSB not written");
   AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
      seq_data(`TS_CMD_LOW_THRESHOLD, 2'h1)
      |=> low_threshold[3:0] == $past(lk.evt_byte[7:4])) // [RULE_10]
      else $error("low threshold LSB not written");
   AST_TWO_BYTES_MAX: assert property (@(posedge ref_clk) disable iff (rst)
      seq_data(`TS_CMD_HIGH_THRESHOLD, 2'h2)
      |=> $stable(high_threshold)) // [RULE_11]
      else $error("third threshold byte was stored");
   AST_CONFIG_ONE: assert property (@(posedge ref_clk) disable iff (rst)
      (data_evt && cmd == `TS_CMD_CONFIG && idx != 2'h0)
      |=> $stable(cfg)) // [RULE_12]
      else $error("extra config byte was stored");
   AST_START_CONV: assert property (@(posedge ref_clk) disable iff (rst)
      seq_cmd(`TS_CMD_START_CONV) |=> conv_active ##1 conv_run) // [RULE_13]
      else $error("start command did not start conversion");
   AST_ONE_SHOT_END: assert property (@(posedge ref_clk) disable iff (rst)
      (conv_done && cfg[`TS_CFG_ONE_SHOT] && !cmd_evt)
      |=> !conv_active && temperature_result == $past(conv_result)
      ##1 config_status[7]) // [RULE_13]
      else $error("one-shot conversion did not go idle");
   AST_STOP_FINISH: assert property (@(posedge ref_clk) disable iff (rst)
      (seq_cmd(`TS_CMD_STOP_CONV) ##0 (conv_active && !conv_done))
      |=> conv_active && stop_pend) // [RULE_14]
      else $error("stop command cut the conversion short");
   AST_READ_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
      (cmd == `TS_CMD_HIGH_THRESHOLD && $stable(high_threshold)
       && $stable(cmd))
      |=> lk.read_word[15:8] == $past(high_threshold[11:4])) // [RULE_16]
      else $error("read word not MSB first");
   AST_RES_MASK: assert property (@(posedge ref_clk) disable iff (rst)
      (cfg[`TS_CFG_RES_LSB +: 2] == 2'h0)
      |=> high_limit[2:0] == 3'h0 && low_limit[2:0] == 3'h0) // [RULE_18]
      else $error("bits below resolution not masked");
   AST_UNKNOWN_CMD: assert property (@(posedge ref_clk) disable iff (rst)
      (cmd_evt && !conv_done && !(lk.evt_byte inside {`TS_CMD_READ_TEMP,
       `TS_CMD_HIGH_THRESHOLD, `TS_CMD_LOW_THRESHOLD, `TS_CMD_CONFIG,
       `TS_CMD_START_CONV, `TS_CMD_STOP_CONV}))
      |=> $stable(high_threshold) && $stable(low_threshold)
          && $stable(cfg) && $stable(conv_active)) // [RULE_19]
      else $error("unknown command changed state");
   AST_STOP_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
      (conv_done && stop_pend && !cmd_evt) |=> !conv_active) // [RULE_14]
      else $error("stopped converter did not go idle");
   AST_START_WINS: assert property (@(posedge ref_clk) disable iff (rst)
      seq_cmd(`TS_CMD_START_CONV) |=> !stop_pend) // [RULE_13]
      else $error("start command left a stop pending");
   AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
      seq_data(`TS_CMD_CONFIG, 2'h0)
      |=> cfg == $past(lk.evt_byte[6:0])) // [RULE_12]
      else $error("config byte not written");
   AST_HIGH_LSB: assert property (@(posedge ref_clk) disable iff (rst)
      seq_data(`TS_CMD_HIGH_THRESHOLD, 2'h1)
      |=> high_threshold[3:0] == $past(lk.evt_byte[7:4])) // [RULE_11]
      else $error("high threshold LSB not written");
endmodule
`default_nettype wire

// ==== test/twi_master_model.sv ====
// Purpose: Bus master model for the sensor's two-wire port.
// Assumes: The bench resolves sda from every pull-down.
// Notes:   scl stands high between frames; 12 ns bit period.
`timescale 1ns/1ps
`default_nettype none
module twi_master_model (
   output var  logic scl,
   output var  logic pull,
   input  wire logic sda
);
   initial {scl, pull} = 2'b10;
   // The link logic needs bus clock edges while it is held in reset.
   task automatic clocks;
      repeat (2) begin
         #6 scl = 1'b0;
         #6 scl = 1'b1;
      end
   endtask
   task automatic bit_io(input logic b, output logic r);
      #3 pull = ~b;
      #3 scl = 1'b1;
      r = sda;
      #6 scl = 1'b0;
   endtask
   task automatic start;
      pull = 1'b0;
      #6 scl = 1'b1;
      #40 pull = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic stop;
      #3 pull = 1'b1;
      #3 scl = 1'b1;
      #40 pull = 1'b0;
      #40;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Only the final byte is refused, so the device lets go of the line.
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

// ==== test/temp_sensor_i2c_command_decoder_tb.sv ====
// Purpose: Self-checking bench of the sensor command decoder.
// Assumes: The master model owns scl; sda is resolved here.
// Notes:   Expected images are rebuilt from the values written.
`timescale 1ns/1ps
`default_nettype none
`include "tsens_consts.svh"
module temp_sensor_i2c_command_decoder_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        conv_done = 1'b0;
   logic [11:0] conv_result = 12'h000;
   logic [2:0]  pins;
   logic        scl, pull, sda, sda_out, sda_oe, conv_run, ack;
   logic [7:0]  config_status, aw;
   logic [11:0] high_limit, low_limit, th, tl, res;
   logic [15:0] v;
   int          n_mismatch = 0;
   int          n_compared = 0;
   assign sda = ~(pull | (sda_oe & ~sda_out));
   assign aw = {`TS_FAMILY_CODE, pins, 1'b0};
   always #2.5 ref_clk = ~ref_clk;
   twi_master_model m (.scl, .pull, .sda);
   temp_sensor_i2c_command_decoder DUT (.ref_clk, .rst, .scl, .sda_in(sda),
      .addr_pin_2(pins[2]), .addr_pin_1(pins[1]), .addr_pin_0(pins[0]),
      .conv_done, .conv_result, .sda_out, .sda_oe, .conv_run,
      .config_status, .high_limit, .low_limit);
   task automatic chk(input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic frame(input logic [7:0] a, c, input int n,
                        input logic [15:0] d, input logic fin);
      m.start();
      m.wr_byte(a, ack);
      chk(ack, a[7:1] == {`TS_FAMILY_CODE, pins});
      if (ack) begin
         m.wr_byte(c, ack);
         chk(ack, 1);
         for (int i = 0; i < n; i++) begin
            m.wr_byte(i < 2 ? d[15-8*i -: 8] : ~d[15:8], ack);
            chk(ack, 1);
         end
      end
      if (fin) m.stop();
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] q);
      frame(aw, c, 0, 16'h0000, 1'b0);
      m.start();
      m.wr_byte(aw | 8'h01, ack);
      chk(ack, 1);
      m.rd_byte(1'b0, q[15:8]);
      m.rd_byte(1'b1, q[7:0]);
      #2 chk(sda_oe, 0);
      m.stop();
   endtask
   task automatic done_pulse(input logic [11:0] r);
      @(posedge ref_clk);
      conv_done <= 1'b1;
      conv_result <= r;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      res = 12'($urandom(32'hcb9bc5b5));
      pins = 3'($urandom);
      fork
         m.clocks();
         repeat (6) @(posedge ref_clk);
      join
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int k = 0; k < 9; k++)
         frame({k[3] ? 4'h8 : `TS_FAMILY_CODE, k[2:0], 1'b0}, 8'h3C, 0,
               16'h0000, 1'b1);
      chk(config_status, {1'b1, `TS_CFG_RST});
      chk(high_limit, `TS_HIGH_THRESHOLD_RST);
      chk(low_limit, `TS_LOW_THRESHOLD_RST);
      $display("address test done");
      th = 12'($urandom);
      tl = 12'($urandom);
      frame(aw, `TS_CMD_HIGH_THRESHOLD, 3, {th, 4'h0}, 1'b1);
      frame(aw, `TS_CMD_LOW_THRESHOLD, 2, {tl, 4'h0}, 1'b1);
      frame(aw, `TS_CMD_LOW_THRESHOLD, 1, {~tl, 4'h0}, 1'b1);
      chk(high_limit, th);
      chk(low_limit, {~tl[11:4], tl[3:0]});
      rd(`TS_CMD_HIGH_THRESHOLD, v);
      chk(v, {th, 4'h0});
      rd(`TS_CMD_LOW_THRESHOLD, v);
      chk(v, {~tl[11:4], tl[3:0], 4'h0});
      frame(aw, `TS_CMD_CONFIG, 2, 16'h0100, 1'b1);
      chk(config_status, 8'h81);
      chk(high_limit, th & 12'hFF8);
      rd(`TS_CMD_CONFIG, v);
      chk(v, 16'h81FF);
      $display("register test done");
      frame(aw, `TS_CMD_START_CONV, 0, 16'h0000, 1'b1);
      chk(conv_run, 1);
      done_pulse(res);
      chk(conv_run, 0);
      rd(`TS_CMD_READ_TEMP, v);
      chk(v, {res, 4'h0});
      chk(conv_run, 0);
      $display("one-shot test done");
      frame(aw, `TS_CMD_CONFIG, 1, 16'h0C00, 1'b1);
      frame(aw, `TS_CMD_START_CONV, 0, 16'h0000, 1'b1);
      done_pulse(~res);
      chk(conv_run, 1);
      frame(aw, `TS_CMD_STOP_CONV, 0, 16'h0000, 1'b1);
      chk(conv_run, 1);
      done_pulse(res);
      chk(config_status, 8'h8C);
      $display("continuous test done");
      print_verdict();
   end
endmodule
`default_nettype wire
